// ==== core/freq_ctrl_pkg.sv ====
// constants and register map of the synthesizer frequency control block
package freq_ctrl_pkg;
  // register addresses
  localparam logic [6:0] ADDR_LIMIT = 7'h2a;
  localparam logic [6:0] ADDR_CORR = 7'h2b;
  localparam logic [6:0] ADDR_RX_CTRL = 7'h08;
  localparam logic [6:0] ADDR_AFC_CTRL = 7'h1d;
  localparam logic [6:0] ADDR_AFC_GEAR = 7'h1e;
  localparam logic [6:0] ADDR_SCALE = 7'h70;
  localparam logic [6:0] ADDR_RATE_HI = 7'h6e;
  localparam logic [6:0] ADDR_RATE_LO = 7'h6f;
  localparam logic [6:0] ADDR_MOD2 = 7'h71;
  localparam logic [6:0] ADDR_DEV = 7'h72;
  localparam logic [6:0] ADDR_OFS_LO = 7'h73;
  localparam logic [6:0] ADDR_OFS_HI = 7'h74;
  localparam logic [6:0] ADDR_BAND = 7'h75;
  // reset values
  localparam logic [7:0] RST_RATE_HI = 8'h0a;
  localparam logic [7:0] RST_RATE_LO = 8'h3d;
  localparam logic [7:0] RST_MOD2 = 8'h00;
  localparam logic [7:0] RST_DEV = 8'h20;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_BAND = 8'h35;
  localparam logic [7:0] RST_AFC_CTRL = 8'h41;
  localparam logic [7:0] RST_AFC_GEAR = 8'h00;
  localparam logic [7:0] RST_LIMIT = 8'h00;
  // field positions and widths
  localparam int MOD2_DEV_MSB = 2;
  localparam int BAND_HB = 5;
  localparam int RX_MPK = 4;
  localparam int AFC_EN = 6;
  localparam int SCALE_BIT = 5;
  localparam int OFS_HI_W = 2;
  // frequency steps, in millihertz
  localparam int DEV_STEP_MHZ = 625000;
  localparam int OFS_STEP_MHZ = 156250;
  // rate accumulator: 25 MHz clock, 1 MHz reference of the rate word
  localparam int CLK_HZ = 25000000;
  localparam int REF_HZ = 1000000;
  localparam int REF_DIV = CLK_HZ / REF_HZ;
  localparam int RATE_FRAC = 16;
  localparam int RATE_SCALE_SHIFT = 5;
  localparam int ACC_W = RATE_FRAC + RATE_SCALE_SHIFT;
  // afc cycle timing, in bit periods
  localparam logic [3:0] MEAS_BITS = 4'h2;
  localparam logic [2:0] SHWAIT_OFF = 3'h0;
endpackage

// ==== core/bit_rate_gen.sv ====
// transmit bit clock generator from a 16-bit rate word
`timescale 1ns/10ps
module bit_rate_gen (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // configuration
  input wire logic [15:0] rate_word,
  input wire logic scale,
  input wire logic run,
  // bit tick
  output logic bit_tick
);
  typedef struct packed {
    logic [4:0] pre;
    logic [freq_ctrl_pkg::ACC_W:0] acc;
    logic tick;
  } state_t;
  state_t st_reg, st_next;
  logic [freq_ctrl_pkg::ACC_W:0] sum;
  logic [freq_ctrl_pkg::ACC_W:0] top;
  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    top = scale ? (freq_ctrl_pkg::ACC_W + 1)'(1) << freq_ctrl_pkg::ACC_W
                : (freq_ctrl_pkg::ACC_W + 1)'(1) << freq_ctrl_pkg::RATE_FRAC;
    sum = st_reg.acc + {{(freq_ctrl_pkg::ACC_W - 15){1'b0}}, rate_word};
    if (!run) begin
      st_next.pre = '0;
      st_next.acc = '0;
    end else if (st_reg.pre == 5'(freq_ctrl_pkg::REF_DIV - 1)) begin
      // one 1 MHz reference step: add the word, wrap at 2^(16+5*scale)
      st_next.pre = '0;
      if (sum >= top) begin
        st_next.acc = sum - top;
        st_next.tick = 1'b1;
      end else begin
        st_next.acc = sum;
      end
    end else begin
      st_next.pre = st_reg.pre + 5'h01;
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign bit_tick = st_reg.tick;
endmodule

// ==== core/synth_freq_ctrl.sv ====
// deviation, offset, afc loop and tx bit rate control of the synthesizer
`timescale 1ns/10ps
module synth_freq_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // register port
  input wire logic reg_wr,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // radio state
  input wire logic tx_mode,
  input wire logic rx_mode,
  input wire logic preamble_det,
  input wire logic packet_end,
  input wire logic rx_bit_tick,
  input wire logic signed [9:0] freq_error,
  // synthesizer controls
  output logic [8:0] deviation_code,
  output logic signed [9:0] offset_term,
  output logic high_band,
  output logic multi_packet,
  output logic tx_bit_tick
);
  typedef enum logic [2:0] {
    AFC_IDLE = 3'b001,
    AFC_MEAS = 3'b010,
    AFC_SETTLE = 3'b100
  } afc_state_t;

  typedef struct packed {
    logic [7:0] rate_hi;
    logic [7:0] rate_lo;
    logic [7:0] scale;
    logic [7:0] mod2;
    logic [7:0] dev;
    logic [7:0] ofs_lo;
    logic [1:0] ofs_hi;
    logic [7:0] band;
    logic [7:0] rx_ctrl;
    logic [7:0] afc_ctrl;
    logic [7:0] afc_gear;
    logic [7:0] limit;
    afc_state_t fsm;
    logic [3:0] bits;
    logic signed [13:0] err_acc;
    logic signed [9:0] corr;
    logic frozen;
    logic [7:0] rdata;
    logic [8:0] dev_out;
    logic signed [9:0] ofs_out;
    logic pre_s1;
    logic pre_s2;
    logic end_s1;
    logic end_s2;
    logic tick_s1;
    logic tick_s2;
    logic tick_d;
  } state_t;

  state_t st_reg, st_next;

  // halve the error gear times, arithmetic shift keeps the sign
  function automatic logic signed [9:0] gear_scale(input logic signed [9:0] e,
                                                   input logic [2:0] g);
    gear_scale = e >>> g;
  endfunction

  // clamp a signed correction to plus or minus the unsigned limit
  function automatic logic signed [9:0] clamp(input logic signed [10:0] v,
                                              input logic [7:0] lim);
    logic signed [10:0] l;
    l = $signed({3'b000, lim});
    if (v > l) begin
      clamp = 10'(l);
    end else if (v < -l) begin
      clamp = 10'(-l);
    end else begin
      clamp = 10'(v);
    end
  endfunction

  function automatic logic is_addr(input logic [6:0] a, input logic [6:0] b);
    is_addr = (a == b);
  endfunction

  logic afc_on;
  logic [2:0] shwait;
  logic [2:0] gear;
  logic [3:0] settle_bits;
  logic bit_edge;
  logic signed [9:0] manual_ofs;
  logic tick_int;

  always_comb begin
    st_next = st_reg;
    afc_on = st_reg.afc_ctrl[freq_ctrl_pkg::AFC_EN];
    shwait = st_reg.afc_ctrl[2:0];
    gear = st_reg.afc_gear[5:3];
    // two measure bits, then 2*shwait settling bits: the default 001 gives two, a four-bit cycle
    settle_bits = {shwait, 1'b0};
    bit_edge = st_reg.tick_s2 & ~st_reg.tick_d;
    manual_ofs = $signed({st_reg.ofs_hi, st_reg.ofs_lo});

    // pin synchronisers
    st_next.pre_s1 = preamble_det;
    st_next.pre_s2 = st_reg.pre_s1;
    st_next.end_s1 = packet_end;
    st_next.end_s2 = st_reg.end_s1;
    st_next.tick_s1 = rx_bit_tick;
    st_next.tick_s2 = st_reg.tick_s1;
    st_next.tick_d = st_reg.tick_s2;

    // register writes
    if (reg_wr) begin
      if (is_addr(reg_addr, freq_ctrl_pkg::ADDR_RATE_HI)) st_next.rate_hi = reg_wdata;
      if (is_addr(reg_addr, freq_ctrl_pkg::ADDR_RATE_LO)) st_next.rate_lo = reg_wdata;
      if (is_addr(reg_addr, freq_ctrl_pkg::ADDR_SCALE)) st_next.scale = reg_wdata;
      if (is_addr(reg_addr, freq_ctrl_pkg::ADDR_MOD2)) st_next.mod2 = reg_wdata;
      if (is_addr(reg_addr, freq_ctrl_pkg::ADDR_DEV)) st_next.dev = reg_wdata;
      if (is_addr(reg_addr, freq_ctrl_pkg::ADDR_OFS_LO)) st_next.ofs_lo = reg_wdata;
      if (is_addr(reg_addr, freq_ctrl_pkg::ADDR_OFS_HI)) begin
        st_next.ofs_hi = reg_wdata[freq_ctrl_pkg::OFS_HI_W - 1:0];
      end
      if (is_addr(reg_addr, freq_ctrl_pkg::ADDR_BAND)) st_next.band = reg_wdata;
      if (is_addr(reg_addr, freq_ctrl_pkg::ADDR_RX_CTRL)) st_next.rx_ctrl = reg_wdata;
      if (is_addr(reg_addr, freq_ctrl_pkg::ADDR_AFC_CTRL)) st_next.afc_ctrl = reg_wdata;
      if (is_addr(reg_addr, freq_ctrl_pkg::ADDR_AFC_GEAR)) st_next.afc_gear = reg_wdata;
      if (is_addr(reg_addr, freq_ctrl_pkg::ADDR_LIMIT)) st_next.limit = reg_wdata;
    end

    // register reads, registered one cycle later
    case (reg_addr)
      freq_ctrl_pkg::ADDR_RATE_HI: st_next.rdata = st_reg.rate_hi;
      freq_ctrl_pkg::ADDR_RATE_LO: st_next.rdata = st_reg.rate_lo;
      freq_ctrl_pkg::ADDR_SCALE: st_next.rdata = st_reg.scale;
      freq_ctrl_pkg::ADDR_MOD2: st_next.rdata = st_reg.mod2;
      freq_ctrl_pkg::ADDR_DEV: st_next.rdata = st_reg.dev;
      freq_ctrl_pkg::ADDR_OFS_LO: st_next.rdata = st_reg.ofs_lo;
      freq_ctrl_pkg::ADDR_OFS_HI: st_next.rdata = {6'h00, st_reg.ofs_hi};
      freq_ctrl_pkg::ADDR_BAND: st_next.rdata = st_reg.band;
      freq_ctrl_pkg::ADDR_RX_CTRL: st_next.rdata = st_reg.rx_ctrl;
      freq_ctrl_pkg::ADDR_AFC_CTRL: st_next.rdata = st_reg.afc_ctrl;
      freq_ctrl_pkg::ADDR_AFC_GEAR: st_next.rdata = st_reg.afc_gear;
      freq_ctrl_pkg::ADDR_LIMIT: st_next.rdata = st_reg.limit;
      freq_ctrl_pkg::ADDR_CORR: st_next.rdata = st_reg.corr[7:0];
      default: st_next.rdata = 8'h00;
    endcase

    // afc loop
    if (!rx_mode || !afc_on) begin
      st_next.fsm = AFC_IDLE;
      st_next.bits = '0;
      st_next.err_acc = '0;
      st_next.frozen = 1'b0;
      if (!afc_on) st_next.corr = '0;
    end else if (st_reg.end_s2 && st_reg.rx_ctrl[freq_ctrl_pkg::RX_MPK]) begin
      // packet done: clear and reacquire
      st_next.corr = '0;
      st_next.frozen = 1'b0;
      st_next.fsm = AFC_IDLE;
      st_next.bits = '0;
      st_next.err_acc = '0;
    end else if (st_reg.pre_s2 || st_reg.frozen) begin
      st_next.frozen = 1'b1;
      st_next.fsm = AFC_IDLE;
    end else begin
      case (st_reg.fsm)
        AFC_IDLE: begin
          if (shwait != freq_ctrl_pkg::SHWAIT_OFF) begin
            st_next.fsm = AFC_MEAS;
            st_next.bits = '0;
            st_next.err_acc = '0;
          end
        end
        AFC_MEAS: begin
          if (bit_edge) begin
            st_next.err_acc = st_reg.err_acc + 14'(freq_error);
            st_next.bits = st_reg.bits + 4'h1;
            if (st_reg.bits + 4'h1 == freq_ctrl_pkg::MEAS_BITS) begin
              // two-bit average applied with gear and limiter
              st_next.corr = clamp(11'(st_reg.corr) + 11'(gear_scale(
                10'((st_reg.err_acc + 14'(freq_error)) >>> 1), gear)),
                st_reg.limit);
              st_next.bits = '0;
              st_next.fsm = AFC_SETTLE;
            end
          end
        end
        AFC_SETTLE: begin
          if (bit_edge) st_next.bits = st_reg.bits + 4'h1;
          if (st_reg.bits >= settle_bits) begin
            st_next.fsm = AFC_IDLE;
            st_next.bits = '0;
          end
        end
        default: st_next.fsm = AFC_IDLE;
      endcase
    end

    // outputs; deviation uses the 625 Hz step in either band
    st_next.dev_out = {st_reg.mod2[freq_ctrl_pkg::MOD2_DEV_MSB], st_reg.dev};
    if (rx_mode && !tx_mode && afc_on) begin
      st_next.ofs_out = (shwait == freq_ctrl_pkg::SHWAIT_OFF) ? 10'sh000
                                                               : st_reg.corr;
    end else begin
      st_next.ofs_out = manual_ofs;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= '0;
      st_reg.rate_hi <= freq_ctrl_pkg::RST_RATE_HI;
      st_reg.rate_lo <= freq_ctrl_pkg::RST_RATE_LO;
      st_reg.scale <= freq_ctrl_pkg::RST_ZERO;
      st_reg.mod2 <= freq_ctrl_pkg::RST_MOD2;
      st_reg.dev <= freq_ctrl_pkg::RST_DEV;
      st_reg.band <= freq_ctrl_pkg::RST_BAND;
      st_reg.afc_ctrl <= freq_ctrl_pkg::RST_AFC_CTRL;
      st_reg.afc_gear <= freq_ctrl_pkg::RST_AFC_GEAR;
      st_reg.limit <= freq_ctrl_pkg::RST_LIMIT;
      st_reg.fsm <= AFC_IDLE;
      st_reg.dev_out <= {1'b0, freq_ctrl_pkg::RST_DEV};
    end else begin
      st_reg <= st_next;
    end
  end

  // rate generator runs only in transmit
  bit_rate_gen u_rate (
    .clk(clk),
    .srst(srst),
    .rate_word({st_reg.rate_hi, st_reg.rate_lo}),
    .scale(st_reg.scale[freq_ctrl_pkg::SCALE_BIT]),
    .run(tx_mode),
    .bit_tick(tick_int)
  );

  assign tx_bit_tick = tick_int;
  assign reg_rdata = st_reg.rdata;
  assign deviation_code = st_reg.dev_out;
  assign offset_term = st_reg.ofs_out;
  assign high_band = st_reg.band[freq_ctrl_pkg::BAND_HB];
  assign multi_packet = st_reg.rx_ctrl[freq_ctrl_pkg::RX_MPK];
endmodule

// ==== verification/synth_freq_ctrl_checker.sv ====
// port assertions of the synthesizer frequency control block
`timescale 1ns/10ps
module synth_freq_ctrl_checker (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // bus
  input wire logic reg_wr,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // radio
  input wire logic tx_mode,
  input wire logic rx_mode,
  input wire logic preamble_det,
  input wire logic packet_end,
  // outputs
  input wire logic [8:0] deviation_code,
  input wire logic signed [9:0] offset_term,
  input wire logic high_band,
  input wire logic multi_packet,
  input wire logic tx_bit_tick
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  a_reset_state: assert property ($fell(srst) |-> deviation_code == 9'h020 &&
    offset_term == 10'sh000 && high_band && !multi_packet && !tx_bit_tick)
    else $error("bad reset state");
  a_dev_low: assert property (reg_wr && reg_addr == 7'h72 |->
    ##2 deviation_code[7:0] == $past(reg_wdata, 2)) else $error("bad deviation");
  a_dev_msb: assert property (reg_wr && reg_addr == 7'h71 |->
    ##2 deviation_code[8] == $past(reg_wdata[2], 2)) else $error("bad deviation msb");
  a_band_no_scale: assert property (reg_wr && reg_addr == 7'h75 && !$past(reg_wr)
    |=> ##1 $stable(deviation_code)) else $error("band moved deviation");
  a_band_follow: assert property (reg_wr && reg_addr == 7'h75 |->
    ##2 high_band == $past(reg_wdata[5], 2)) else $error("bad band");
  a_multi_follow: assert property (reg_wr && reg_addr == 7'h08 |->
    ##2 multi_packet == $past(reg_wdata[4], 2)) else $error("bad multi packet");
  a_unmapped_zero: assert property (reg_addr == 7'h00 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_limit_back: assert property (reg_wr && reg_addr == 7'h2a ##1 !reg_wr &&
    reg_addr == 7'h2a |=> reg_rdata == $past(reg_wdata, 2)) else $error("bad limit");
  a_tick_single: assert property (tx_bit_tick |=> !tx_bit_tick)
    else $error("tick too long");
  a_tick_tx_only: assert property ((!tx_mode) [*4] |-> !tx_bit_tick)
    else $error("tick outside transmit");
  a_freeze_hold: assert property ((preamble_det && rx_mode && !tx_mode &&
    !packet_end && !reg_wr) [*6] |=> $stable(offset_term)) else $error("not frozen");
endmodule
bind synth_freq_ctrl synth_freq_ctrl_checker u_checker (
  .clk, .srst, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .tx_mode, .rx_mode,
  .preamble_det, .packet_end, .deviation_code, .offset_term, .high_band,
  .multi_packet, .tx_bit_tick
);

// ==== verification/test_synth_freq_ctrl.sv ====
// self-checking bench of the synthesizer frequency control block
`timescale 1ns/10ps
module test_synth_freq_ctrl;
  // address and reset value of each register but scale (70) and rx control (08), unmapped last
  localparam logic [15:0] RV [12] = '{16'h6e0a, 16'h6f3d, 16'h7100, 16'h7220,
    16'h7300, 16'h7400, 16'h7535, 16'h1d41, 16'h1e00, 16'h2a00, 16'h2b00, 16'h0000};
  logic clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, tx_mode = 1'b0, rx_mode = 1'b0;
  logic preamble_det = 1'b0, packet_end = 1'b0, rx_bit_tick = 1'b0;
  logic [6:0] reg_addr = 7'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic signed [9:0] freq_error = 10'sh000;
  logic [7:0] reg_rdata;
  logic [8:0] deviation_code;
  logic signed [9:0] offset_term;
  logic high_band, multi_packet, tx_bit_tick;
  logic [1:0] probe = 2'h0;
  logic [15:0] exp_q [$];
  int gap_q [$];
  int gap = 0, failures = 0, checks = 0;

  synth_freq_ctrl u_synth_freq_ctrl (
    .clk, .srst, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .tx_mode, .rx_mode,
    .preamble_det, .packet_end, .rx_bit_tick, .freq_error, .deviation_code,
    .offset_term, .high_band, .multi_packet, .tx_bit_tick
  );

  initial begin
    forever #20 clk = ~clk;
  end
  task automatic cmp_val(logic [15:0] g, logic [15:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic cmp_gap(int g, int e);
    checks++;
    if (g != e) begin
      failures++;
      $display("CHECK FAILED at %0t: tick gap %0d want %0d", $time, g, e);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // results are sampled mid-cycle, away from the launching edge
  always @(negedge clk) begin
    logic [15:0] e;
    if (probe != 2'h0) begin
      e = exp_q.pop_front();
      case (probe)
        2'h1: cmp_val({8'h00, reg_rdata}, e);
        2'h2: cmp_val({6'h00, offset_term}, e);
        default: cmp_val({5'h00, high_band, multi_packet, deviation_code}, e);
      endcase
    end
    gap++;
    if (tx_bit_tick === 1'b1) begin
      if (gap_q.size() > 0)
        cmp_gap(gap, gap_q.pop_front());
      gap = 0;
    end
  end
  task automatic step(int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(logic [6:0] a, logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    step();
    reg_wr = 1'b0;
    step();
  endtask
  task automatic chk(logic [1:0] k, logic [15:0] e);
    exp_q.push_back(e);
    probe = k;
    step();
    probe = 2'h0;
  endtask
  task automatic rd(logic [6:0] a, logic [7:0] e);
    reg_addr = a;
    step();
    chk(2'h1, {8'h00, e});
  endtask
  task automatic bits(int n);
    repeat (n) begin
      rx_bit_tick = 1'b1;
      step(4);
      rx_bit_tick = 1'b0;
      step(4);
    end
  endtask
  task automatic tick;
    int i;
    for (i = 0; i < 4000; i++) begin
      step();
      if (tx_bit_tick === 1'b1)
        break;
    end
    if (i == 4000) begin
      failures++;
      $display("CHECK FAILED at %0t: no tx bit tick", $time);
    end
  endtask
  // transmit off restarts the accumulator; the first two ticks are not timed
  task automatic rate(logic [15:0] w, logic s, int n);
    tx_mode = 1'b0;
    wr(7'h70, {2'h0, s, 5'h00});
    wr(7'h58, (w > 16'h199a && !s) ? 8'hc0 : 8'h80);
    wr(7'h6e, w[15:8]);
    wr(7'h6f, w[7:0]);
    tx_mode = 1'b1;
    tick();
    tick();
    step();
    gap_q.push_back(n);
    tick();
    step();
  endtask
  // restart the loop from a cleared correction and measure two bits
  task automatic afc(logic [7:0] c, logic [7:0] g, logic [7:0] l, logic signed [9:0] er);
    rx_mode = 1'b0;
    wr(7'h1d, 8'h01);
    wr(7'h1e, g);
    wr(7'h2a, l);
    rd(7'h2a, l);
    wr(7'h1d, c);
    freq_error = er;
    rx_mode = 1'b1;
    step(2);
    bits(2);
    step(6);
  endtask
  task automatic done(string s);
    $display("test %s finished", s);
  endtask
  initial begin
    #1000000;
    failures++;
    wrap_up();
  end
  initial begin
    logic [8:0] d;
    int k;
    void'($urandom(32'h45f22879));
    step(6);
    srst = 1'b0;
    step();
    chk(2'h3, 16'h0420);
    chk(2'h2, 16'h0000);
    for (int i = 0; i < 12; i++)
      rd(RV[i][14:8], RV[i][7:0]);
    done("reset");
    d = 9'($urandom);
    wr(7'h72, d[7:0]);
    wr(7'h71, {5'h00, d[8], 2'h0});
    step(2);
    chk(2'h3, {5'h00, 2'h2, d});
    wr(7'h75, 8'h15);
    step(2);
    chk(2'h3, {5'h00, 2'h0, d});
    wr(7'h75, 8'h35);
    done("deviation");
    afc(8'h41, 8'h00, 8'hff, 10'sh008);
    rd(7'h2b, 8'h08);
    chk(2'h2, 16'h0008);
    // the next two bits are the settling half of the cycle
    bits(2);
    rd(7'h2b, 8'h08);
    preamble_det = 1'b1;
    step(8);
    freq_error = 10'sh014;
    bits(4);
    rd(7'h2b, 8'h08);
    wr(7'h08, 8'h10);
    chk(2'h3, {5'h00, 2'h3, d});
    preamble_det = 1'b0;
    packet_end = 1'b1;
    step(3);
    packet_end = 1'b0;
    step(6);
    rd(7'h2b, 8'h00);
    freq_error = 10'sh003;
    bits(2);
    step(6);
    rd(7'h2b, 8'h03);
    wr(7'h08, 8'h00);
    afc(8'h41, 8'h08, 8'hff, 10'sh008);
    rd(7'h2b, 8'h04);
    afc(8'h41, 8'h00, 8'h05, 10'sh008);
    rd(7'h2b, 8'h05);
    afc(8'h41, 8'h00, 8'h03, -10'sh008);
    rd(7'h2b, 8'hfd);
    afc(8'h41, 8'h00, 8'hff, -10'sh008);
    chk(2'h2, 16'h03f8);
    afc(8'h40, 8'h00, 8'hff, 10'sh008);
    chk(2'h2, 16'h0000);
    done("afc");
    rx_mode = 1'b0;
    tx_mode = 1'b1;
    wr(7'h1d, 8'h41);
    wr(7'h74, 8'hff);
    wr(7'h73, 8'h60);
    step(2);
    chk(2'h2, 16'h0360);
    rd(7'h74, 8'h03);
    tx_mode = 1'b0;
    wr(7'h1d, 8'h01);
    rx_mode = 1'b1;
    step(6);
    chk(2'h2, 16'h0360);
    rx_mode = 1'b0;
    done("offset");
    rate(16'h4000, 1'b0, 100);
    rate(16'h8000, 1'b1, 1600);
    k = $urandom_range(14, 12);
    rate(16'(1 << k), 1'b0, 25 << (16 - k));
    tx_mode = 1'b0;
    step(8);
    done("rate");
    wrap_up();
  end
endmodule
